// ---- core/ldomps_consts.svh ----
`ifndef LDOMPS_CONSTS_SVH
`define LDOMPS_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define LDOMPS_IDX_LOWER 8'h98
`define LDOMPS_IDX_UPPER 8'h99
`define LDOMPS_IDX_SOURCE 8'h9a
`define LDOMPS_IDX_STATUS 8'h9b

// Reset values of the writable registers.
`define LDOMPS_RST_LOWER 8'h00
`define LDOMPS_RST_UPPER 8'h00
`define LDOMPS_RST_SOURCE 8'h00

// Each regulator owns a two-bit field; regulator n sits at bit 6 - 2n.
`define LDOMPS_FIELD_TOP 6
`define LDOMPS_FIELD_STEP 2

// Source selection code that puts a regulator under direct control.
`define LDOMPS_SRC_DIRECT 2'h3

// Status register layout.
`define LDOMPS_STAT_EN_LSB 0
`define LDOMPS_STAT_LP_LSB 4
`define LDOMPS_STAT_SEQ_LSB 8
`define LDOMPS_STAT_GLP_BIT 11

// Upper address bits must be zero for a register hit.
`define LDOMPS_ADDR_HI_ZERO 22'h000000

`endif

// ---- core/ldomps_mode_decode.sv ----
`timescale 1ns/10ps
// Turns one regulator's mode field and source selection into enable and low-power levels.
module ldomps_mode_decode (
    input wire ldomps_pkg::ldomps_mode_e mode_in,
    input wire ldomps_pkg::ldomps_src_t src_in,
    input wire logic [2:0] sequencer_enable_in,
    input wire logic global_low_power_in,
    output logic enable_out,
    output logic low_power_out
);
    import ldomps_pkg::*;

    // Gate vector: the top entry stands for direct control and is always open.
    logic [3:0] gate_vec;
    // Permission to run from the selected sequencer, or always under direct control.
    logic gate;
    // Low-power request of an enabled regulator.
    logic lp_req;

    assign gate_vec = {1'b1, sequencer_enable_in};
    // Code 3 picks the constant one, so direct control ignores every sequencer.
    assign gate = gate_vec[src_in];
    // Mode zero is off under any source; any other mode runs while the gate is open.
    assign enable_out = (mode_in != MODE_OFF) && gate;
    // Mode one follows the global signal, mode two is forced low power, mode three normal.
    assign lp_req = (mode_in == MODE_LOWPWR) || ((mode_in == MODE_GLOBAL) && global_low_power_in);
    // A disabled regulator never reports low power.
    assign low_power_out = enable_out && lp_req;
endmodule

// ---- core/ldomps_pkg.sv ----
package ldomps_pkg;

    // Two-bit power mode field codes.
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_GLOBAL = 2'b01,
        MODE_LOWPWR = 2'b10,
        MODE_NORMAL = 2'b11
    } ldomps_mode_e;

    // Sequencer source selection field.
    typedef logic [1:0] ldomps_src_t;

    // One byte wide register value.
    typedef logic [7:0] ldomps_byte_t;

    // One bit for each of the four decoded regulators.
    typedef logic [3:0] ldomps_reg_vec_t;

endpackage

// ---- core/ldomps_reg8.sv ----
`timescale 1ns/10ps
// A byte register that also shows the value it will take at the next edge.
module ldomps_reg8 #(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic wr_en_in,
    input wire ldomps_pkg::ldomps_byte_t wr_data_in,
    output ldomps_pkg::ldomps_byte_t value_out,
    output ldomps_pkg::ldomps_byte_t value_nxt_out
);
    import ldomps_pkg::*;

    // Stored byte.
    ldomps_byte_t value_r;
    // Value after the coming edge, used to forward a write to a read.
    ldomps_byte_t value_nxt;

    // A write replaces the whole byte; otherwise the value holds.
    assign value_nxt = wr_en_in ? wr_data_in : value_r;
    assign value_out = value_r;
    assign value_nxt_out = value_nxt;

    // The register loads its reset value while reset is high.
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            value_r <= RESET_VAL;
        end
        else
        begin
            value_r <= value_nxt;
        end
    end
endmodule

// ---- core/ldomps_top.sv ----
// Contract
// - Source code three means direct control.
// - Mode zero turns the regulator off.
// - Direct mode one follows global low-power.
// - Direct mode two forces low power.
// - Direct mode three forces normal mode.
// - Sequenced mode one gated, follows global low-power.
// - Sequenced mode two gated, low power.
// - Sequenced mode three gated, normal mode.
// - Sequenced regulator off while sequencer disabled.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "ldomps_consts.svh"
module ldomps_top (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    input wire logic [2:0] sequencer_enable_in,
    input wire logic global_low_power_in,
    output ldomps_pkg::ldomps_reg_vec_t regulator_enable_out,
    output ldomps_pkg::ldomps_reg_vec_t regulator_low_power_out
);
    import ldomps_pkg::*;

    // Address phase decode.

    // A transfer is taken when selected, the bus is ready and the type is NONSEQ or SEQ.
    logic ahb_take;
    // Word index carried by the address.
    logic [7:0] addr_idx;
    // High when the unused address bits are zero.
    logic addr_hi_ok;
    // Hit on the lower mode register in the address phase.
    logic hit_lower;
    // Hit on the upper mode register, which is storage only.
    logic hit_upper;
    // Hit on the source selection register.
    logic hit_source;
    // Hit on the read-only status word.
    logic hit_status;

    assign ahb_take = hsel_in && hready_in && htrans_in[1];
    assign addr_idx = haddr_in[9:2];
    assign addr_hi_ok = (haddr_in[31:10] == `LDOMPS_ADDR_HI_ZERO);
    assign hit_lower = addr_hi_ok && (addr_idx == `LDOMPS_IDX_LOWER);
    assign hit_upper = addr_hi_ok && (addr_idx == `LDOMPS_IDX_UPPER);
    assign hit_source = addr_hi_ok && (addr_idx == `LDOMPS_IDX_SOURCE);
    assign hit_status = addr_hi_ok && (addr_idx == `LDOMPS_IDX_STATUS);

    // Data phase state.

    // Write selects held over from the address phase: lower, upper, source.
    logic [2:0] dph_wr_r;
    logic [2:0] dph_wr_nxt;
    // Read data and response registers driving the bus.
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    // Ready flag, high from reset onward because the slave never stalls.
    logic hreadyout_r;
    // Response flag, always OKAY.
    logic hresp_r;

    // Only a taken write arms a register write for the next cycle.
    assign dph_wr_nxt = (ahb_take && hwrite_in) ? {hit_source, hit_upper, hit_lower} : 3'h0;

    // Register file.

    // Stored lower byte and its value after the coming edge.
    ldomps_byte_t lower_q;
    ldomps_byte_t lower_nxt;
    // Stored upper byte and its value after the coming edge.
    ldomps_byte_t upper_q;
    ldomps_byte_t upper_nxt;
    // Stored source byte and its value after the coming edge.
    ldomps_byte_t source_q;
    ldomps_byte_t source_nxt;

    // The lower register holds the mode fields of regulators zero to three.
    ldomps_reg8 #(
        .RESET_VAL(`LDOMPS_RST_LOWER)
    ) u_lower (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .wr_en_in(dph_wr_r[0]),
        .wr_data_in(hwdata_in[7:0]),
        .value_out(lower_q),
        .value_nxt_out(lower_nxt)
    );

    // The upper register is plain storage for regulators four to seven.
    ldomps_reg8 #(
        .RESET_VAL(`LDOMPS_RST_UPPER)
    ) u_upper (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .wr_en_in(dph_wr_r[1]),
        .wr_data_in(hwdata_in[7:0]),
        .value_out(upper_q),
        .value_nxt_out(upper_nxt)
    );

    // The source register holds the sequencer source selection of regulators zero to three.
    ldomps_reg8 #(
        .RESET_VAL(`LDOMPS_RST_SOURCE)
    ) u_source (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .wr_en_in(dph_wr_r[2]),
        .wr_data_in(hwdata_in[7:0]),
        .value_out(source_q),
        .value_nxt_out(source_nxt)
    );

    // Decoders.

    // Mode and source field of each regulator, taken from the stored registers.
    ldomps_mode_e reg_mode [4];
    ldomps_src_t reg_src [4];
    // Decoded enable of each regulator.
    ldomps_reg_vec_t dec_en;
    // Decoded low-power level of each regulator; low whenever it is off.
    ldomps_reg_vec_t dec_lp;

    // One decoder for each regulator field of the lower register.
    for (genvar gi = 0; gi < 4; gi++)
    begin : g_dec
        // Regulator gi owns the two bits whose low bit is six minus twice its number.
        assign reg_mode[gi] = ldomps_mode_e'(lower_q[`LDOMPS_FIELD_TOP - `LDOMPS_FIELD_STEP * gi +: 2]);
        // Its source field sits at the same place in the source register.
        assign reg_src[gi] = source_q[`LDOMPS_FIELD_TOP - `LDOMPS_FIELD_STEP * gi +: 2];
        ldomps_mode_decode u_dec (
            .mode_in(reg_mode[gi]),
            .src_in(reg_src[gi]),
            .sequencer_enable_in(sequencer_enable_in),
            .global_low_power_in(global_low_power_in),
            .enable_out(dec_en[gi]),
            .low_power_out(dec_lp[gi])
        );
    end

    // The decoded levels leave the block with no register in the path.
    assign regulator_enable_out = dec_en;
    assign regulator_low_power_out = dec_lp;

    // Read path.

    // Status word shows the decoded state and the inputs that steer it.
    logic [31:0] status_word;
    // Read value chosen in the address phase.
    logic [31:0] rd_mux;

    assign status_word = {20'h00000, global_low_power_in, sequencer_enable_in, dec_lp, dec_en};
    // Next values are read so a read right behind a write returns the new byte.
    assign rd_mux = hit_lower ? {24'h000000, lower_nxt} :
                    hit_upper ? {24'h000000, upper_nxt} :
                    hit_source ? {24'h000000, source_nxt} :
                    hit_status ? status_word : 32'h00000000;
    // Read data is loaded at the address phase edge and stands through the data phase.
    assign hrdata_nxt = (ahb_take && !hwrite_in) ? rd_mux : hrdata_r;

    // Bus registers; the slave never inserts wait states and always answers OKAY.
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            dph_wr_r <= 3'h0;
            hrdata_r <= 32'h00000000;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end
        else
        begin
            dph_wr_r <= dph_wr_nxt;
            hrdata_r <= hrdata_nxt;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end
    end

    assign hrdata_out = hrdata_r;
    assign hreadyout_out = hreadyout_r;
    assign hresp_out = hresp_r;

    // Checks.

    // Every check runs on the core clock and rests while reset is high.
    default clocking cb_main @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // Gate of the selected sequencer for each regulator, rebuilt for the checks.
    // It is spelled out code by code so that it does not share the decoder's indexing.
    ldomps_reg_vec_t chk_gate;

    // Per regulator relations between fields, inputs and decoded levels.
    for (genvar ci = 0; ci < 4; ci++)
    begin : g_chk
        // Codes zero to two pick their own sequencer; every user excludes direct control.
        assign chk_gate[ci] = (reg_src[ci] == 2'h0) ? sequencer_enable_in[0] :
                              (reg_src[ci] == 2'h1) ? sequencer_enable_in[1] :
                              sequencer_enable_in[2];

        a_direct_ignores_seq: assert property (
            (reg_src[ci] == `LDOMPS_SRC_DIRECT && $changed(sequencer_enable_in))
            |-> (regulator_enable_out[ci] == (reg_mode[ci] != MODE_OFF)))
            else $error("Direct control regulator followed a sequencer.");

        a_zero_mode_off: assert property (
            (reg_mode[ci] == MODE_OFF) |-> (!regulator_enable_out[ci] && !regulator_low_power_out[ci]))
            else $error("Regulator with mode zero is not off.");

        a_direct_global_follow: assert property (
            (reg_src[ci] == `LDOMPS_SRC_DIRECT && reg_mode[ci] == MODE_GLOBAL)
            |-> (regulator_enable_out[ci] && regulator_low_power_out[ci] == global_low_power_in))
            else $error("Direct mode one does not follow the global signal.");

        a_direct_forced_low: assert property (
            (reg_src[ci] == `LDOMPS_SRC_DIRECT && reg_mode[ci] == MODE_LOWPWR)
            |-> (regulator_enable_out[ci] && regulator_low_power_out[ci]))
            else $error("Direct mode two is not forced low power.");

        a_direct_forced_normal: assert property (
            (reg_src[ci] == `LDOMPS_SRC_DIRECT && reg_mode[ci] == MODE_NORMAL)
            |-> (regulator_enable_out[ci] && !regulator_low_power_out[ci]))
            else $error("Direct mode three is not forced normal.");

        a_seq_global_follow: assert property (
            (reg_src[ci] != `LDOMPS_SRC_DIRECT && reg_mode[ci] == MODE_GLOBAL && chk_gate[ci])
            |-> (regulator_enable_out[ci] && regulator_low_power_out[ci] == global_low_power_in))
            else $error("Sequenced mode one does not follow the global signal.");

        a_seq_low_power: assert property (
            (reg_src[ci] != `LDOMPS_SRC_DIRECT && reg_mode[ci] == MODE_LOWPWR && chk_gate[ci])
            |-> (regulator_enable_out[ci] && regulator_low_power_out[ci]))
            else $error("Sequenced mode two is not low power.");

        a_seq_normal_mode: assert property (
            (reg_src[ci] != `LDOMPS_SRC_DIRECT && reg_mode[ci] == MODE_NORMAL && chk_gate[ci])
            |-> (regulator_enable_out[ci] && !regulator_low_power_out[ci]))
            else $error("Sequenced mode three is not normal.");

        a_seq_off_held: assert property (
            (reg_src[ci] != `LDOMPS_SRC_DIRECT && !chk_gate[ci])
            |-> (!regulator_enable_out[ci] && !regulator_low_power_out[ci]))
            else $error("Sequenced regulator runs while its sequencer is off.");

        a_direct_always_on: assert property (
            (reg_src[ci] == `LDOMPS_SRC_DIRECT && reg_mode[ci] != MODE_OFF) |-> regulator_enable_out[ci])
            else $error("Direct control regulator with nonzero mode is off.");

        a_seq_gate_follow: assert property (
            (reg_src[ci] != `LDOMPS_SRC_DIRECT && reg_mode[ci] != MODE_OFF)
            |-> (regulator_enable_out[ci] == chk_gate[ci]))
            else $error("Sequenced regulator does not follow its sequencer.");
    end

    // A mode write shows on the outputs in the cycle after its data phase, not later.
    a_write_decode_now: assert property (
        (ahb_take && hwrite_in && hit_lower) ##1 (hwdata_in[7:6] == 2'b11 && source_q[7:6] == 2'b11)
        |=> (regulator_enable_out[0] && !regulator_low_power_out[0]))
        else $error("Decoded output lags the written mode field.");

    // A write to the lower register lands two edges after its address phase.
    a_write_lands_lower: assert property (
        (ahb_take && hwrite_in && hit_lower) |-> ##2 (lower_q == $past(hwdata_in[7:0])))
        else $error("Lower register did not take the written byte.");

    // A read of the lower register returns its value in the data phase.
    a_read_returns_lower: assert property (
        (ahb_take && !hwrite_in && hit_lower && dph_wr_r == 3'h0)
        |=> (hrdata_out == {24'h000000, $past(lower_q)}))
        else $error("Read data differs from the lower register.");

    // An unmapped read returns zero.
    a_unmapped_reads_zero: assert property (
        (ahb_take && !hwrite_in && !(hit_lower || hit_upper || hit_source || hit_status))
        |=> (hrdata_out == 32'h00000000))
        else $error("Unmapped read returned nonzero data.");

    // The slave is always ready and always answers OKAY.
    a_ready_okay: assert property (
        hreadyout_out && !hresp_out)
        else $error("Slave stalled or signalled an error.");

    // Low power is never shown for a regulator that is off.
    a_low_power_only_on: assert property (
        (regulator_low_power_out & ~regulator_enable_out) == 4'h0)
        else $error("Low power shown for a disabled regulator.");

    // A write to the upper register lands two edges after its address phase.
    a_write_lands_upper: assert property (
        (ahb_take && hwrite_in && hit_upper) |-> ##2 (upper_q == $past(hwdata_in[7:0])))
        else $error("Upper register did not take the written byte.");

    // A write to the source register lands two edges after its address phase.
    a_write_lands_source: assert property (
        (ahb_take && hwrite_in && hit_source) |-> ##2 (source_q == $past(hwdata_in[7:0])))
        else $error("Source register did not take the written byte.");

    // A write to the status word or an unmapped place leaves every register as it was.
    a_stray_write_ignored: assert property (
        (ahb_take && hwrite_in && !(hit_lower || hit_upper || hit_source))
        |-> ##2 (lower_q == $past(lower_q) && upper_q == $past(upper_q) && source_q == $past(source_q)))
        else $error("A stray write changed a register.");

    // A status read returns the decoded levels and inputs of its address phase.
    a_status_read_word: assert property (
        (ahb_take && !hwrite_in && hit_status)
        |=> (hrdata_out == {20'h00000, $past(global_low_power_in), $past(sequencer_enable_in),
            $past(regulator_low_power_out), $past(regulator_enable_out)}))
        else $error("Status read differs from the decoded state.");

    // Read data stands until the next read is taken.
    a_read_data_stands: assert property (
        !(ahb_take && !hwrite_in) |=> $stable(hrdata_out))
        else $error("Read data changed without a read.");

    // Only a taken write arms a register write.
    a_idle_arms_nothing: assert property (
        !(ahb_take && hwrite_in) |=> (dph_wr_r == 3'h0))
        else $error("A register write was armed without a taken write.");

    // A read of the upper register returns its value in the data phase.
    a_read_returns_upper: assert property (
        (ahb_take && !hwrite_in && hit_upper && dph_wr_r == 3'h0)
        |=> (hrdata_out == {24'h000000, $past(upper_q)}))
        else $error("Read data differs from the upper register.");

    // A read of the source register returns its value in the data phase.
    a_read_returns_source: assert property (
        (ahb_take && !hwrite_in && hit_source && dph_wr_r == 3'h0)
        |=> (hrdata_out == {24'h000000, $past(source_q)}))
        else $error("Read data differs from the source register.");
endmodule

// ---- verification/tb_ldo_power_mode_select.sv ----
`timescale 1ns/10ps
`include "ldomps_consts.svh"
// Self-checking bench: registers over the bus, regulator controls at the pins.
module tb_ldo_power_mode_select;
    import ldomps_pkg::*;
    // One table row: register bytes, input levels, expected controls.
    typedef struct packed {
        logic [7:0] lower;
        logic [7:0] src;
        logic [2:0] seq;
        logic glp;
        logic [3:0] en;
        logic [3:0] lp;
    } ldomps_tb_row_s;
    localparam logic [31:0] A_LOWER = 32'({`LDOMPS_IDX_LOWER, 2'b00});
    localparam logic [31:0] A_UPPER = 32'({`LDOMPS_IDX_UPPER, 2'b00});
    localparam logic [31:0] A_SRC = 32'({`LDOMPS_IDX_SOURCE, 2'b00});
    localparam logic [31:0] A_STAT = 32'({`LDOMPS_IDX_STATUS, 2'b00});
    // Ordinary decode cases; all four fields share a code unless mixed.
    localparam ldomps_tb_row_s ROWS [0:14] = '{
        '{8'h00, 8'hff, 3'h7, 1'b1, 4'h0, 4'h0}, // Direct, mode zero
        '{8'h00, 8'h00, 3'h7, 1'b0, 4'h0, 4'h0}, // Sequenced, mode zero
        '{8'h55, 8'hff, 3'h0, 1'b0, 4'hf, 4'h0}, // Direct one, global low
        '{8'h55, 8'hff, 3'h0, 1'b1, 4'hf, 4'hf}, // Direct one, global high
        '{8'haa, 8'hff, 3'h0, 1'b0, 4'hf, 4'hf}, // Direct two
        '{8'hff, 8'hff, 3'h0, 1'b1, 4'hf, 4'h0}, // Direct three
        '{8'h55, 8'h00, 3'h1, 1'b0, 4'hf, 4'h0}, // Sequenced one, global low
        '{8'h55, 8'h00, 3'h1, 1'b1, 4'hf, 4'hf}, // Sequenced one, global high
        '{8'h55, 8'h00, 3'h6, 1'b1, 4'h0, 4'h0}, // Sequenced one, sequencer off
        '{8'haa, 8'h55, 3'h2, 1'b0, 4'hf, 4'hf}, // Sequenced two
        '{8'haa, 8'h55, 3'h5, 1'b0, 4'h0, 4'h0}, // Sequenced two, sequencer off
        '{8'hff, 8'haa, 3'h4, 1'b1, 4'hf, 4'h0}, // Sequenced three
        '{8'hff, 8'haa, 3'h3, 1'b1, 4'h0, 4'h0}, // Sequenced three, sequencer off
        '{8'h1b, 8'hff, 3'h0, 1'b1, 4'he, 4'h6}, // Mixed modes per field
        '{8'hff, 8'h1b, 3'h2, 1'b0, 4'ha, 4'h0}  // Fields pick sequencers zero to two, field three direct
    };
    logic core_clk;
    logic sys_rst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [2:0] seq_en;
    logic glp;
    ldomps_reg_vec_t reg_en;
    ldomps_reg_vec_t reg_lp;
    int n_errors;
    int total_checks;
    logic [31:0] rdata;
    // The single slave's hreadyout is the bus hready.
    ldomps_top ldomps_top_i (
        .core_clk_in(core_clk),
        .sys_rst_in(sys_rst),
        .hsel_in(hsel),
        .haddr_in(haddr),
        .htrans_in(htrans),
        .hwrite_in(hwrite),
        .hsize_in(hsize),
        .hwdata_in(hwdata),
        .hready_in(hreadyout),
        .hreadyout_out(hreadyout),
        .hresp_out(hresp),
        .hrdata_out(hrdata),
        .sequencer_enable_in(seq_en),
        .global_low_power_in(glp),
        .regulator_enable_out(reg_en),
        .regulator_low_power_out(reg_lp)
    );
    // Free-running 10 MHz clock.
    always #50 core_clk = ~core_clk;
    // Prints the counts and the verdict, then stops the run.
    task automatic results;
        $display("checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Compares one value and reports a mismatch at once.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    // Waits for an edge with hready high, bounded so a stuck slave ends the run.
    task automatic wait_ready;
        int k;
        k = 0;
        @(posedge core_clk);
        while (hreadyout !== 1'b1 && k < 16)
        begin
            @(posedge core_clk);
            k++;
        end
        if (k >= 16)
        begin
            $display("wrong value bus wait: expected ready, seen none");
            n_errors++;
            results();
        end
    endtask
    // One single word transfer; address phase, then data phase with read data taken at its end.
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= addr;
        hwrite <= wr;
        hsize <= 3'b010;
        wait_ready();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wdata;
        wait_ready();
        rdata = hrdata;
        chk("bus response", 32'h0, {31'h0, hresp});
    endtask
    // Reads a register and compares it with the expected word.
    task automatic rd_chk(input string name, input logic [31:0] addr, input logic [31:0] exp);
        bus(1'b0, addr, 32'h0);
        chk(name, exp, rdata);
    endtask
    // Compares the regulator controls mid-cycle, then returns on the next rising edge
    // so that whatever is driven after it changes right after an edge.
    task automatic chk_out(input logic [3:0] en, input logic [3:0] lp);
        chk("regulator enable", {28'h0, en}, {28'h0, reg_en});
        chk("regulator low power", {28'h0, lp}, {28'h0, reg_lp});
        @(posedge core_clk);
    endtask
    // Main sequence: reset, table, then the awkward cases.
    initial
    begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        seq_en = 3'h0;
        glp = 1'b0;
        n_errors = 0;
        total_checks = 0;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        // Reset leaves every regulator off and the registers cleared.
        @(negedge core_clk);
        chk_out(4'h0, 4'h0);
        rd_chk("lower after reset", A_LOWER, 32'h0);
        rd_chk("upper after reset", A_UPPER, 32'h0);
        rd_chk("source after reset", A_SRC, 32'h0);
        rd_chk("status after reset", A_STAT, 32'h0);
        // Table rows: program both registers, set the levels, compare pins and status.
        foreach (ROWS[i])
        begin
            bus(1'b1, A_LOWER, {24'h0, ROWS[i].lower});
            bus(1'b1, A_SRC, {24'h0, ROWS[i].src});
            seq_en <= ROWS[i].seq;
            glp <= ROWS[i].glp;
            @(negedge core_clk);
            chk_out(ROWS[i].en, ROWS[i].lp);
            rd_chk("status", A_STAT, {20'h0, ROWS[i].glp, ROWS[i].seq, ROWS[i].lp, ROWS[i].en});
        end
        // Input level changes must show within the same cycle.
        bus(1'b1, A_LOWER, 32'h55);
        bus(1'b1, A_SRC, 32'hff);
        glp <= 1'b1;
        @(negedge core_clk);
        chk_out(4'hf, 4'hf);
        @(posedge core_clk);
        glp <= 1'b0;
        @(negedge core_clk);
        chk_out(4'hf, 4'h0);
        bus(1'b1, A_SRC, 32'h00);
        seq_en <= 3'h1;
        @(negedge core_clk);
        chk_out(4'hf, 4'h0);
        @(posedge core_clk);
        seq_en <= 3'h0;
        @(negedge core_clk);
        chk_out(4'h0, 4'h0);
        // Upper byte is plain storage; read back in the next transfer, after the write has landed.
        bus(1'b1, A_UPPER, 32'hffff_ffa5);
        rd_chk("upper readback", A_UPPER, 32'ha5);
        // Status is read-only; unmapped places ignore writes and read zero.
        bus(1'b1, A_STAT, 32'hffff_ffff);
        rd_chk("status after write", A_STAT, 32'h0);
        bus(1'b1, 32'h0000_0270, 32'hff);
        bus(1'b1, A_LOWER | 32'h0000_0400, 32'h00);
        rd_chk("lower after stray writes", A_LOWER, 32'h55);
        rd_chk("unmapped read", 32'h0000_0270, 32'h0);
        rd_chk("aliased read", A_LOWER | 32'h0000_0400, 32'h0);
        // A second reset in mid-run clears everything again.
        bus(1'b1, A_SRC, 32'hff);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        chk_out(4'h0, 4'h0);
        rd_chk("lower after reset", A_LOWER, 32'h0);
        rd_chk("upper after reset", A_UPPER, 32'h0);
        rd_chk("source after reset", A_SRC, 32'h0);
        results();
    end
endmodule
